// ==== wwd_top.sv ====
/*
 * Windowed watchdog core: control and status registers, operating modes,
 * clock source and period selection, window check with arming, and the
 * reset or wake decision on expiry or a window violation.
 * Assumes synchronous inputs, configuration levels held stable, and a
 * system that routes sys_reset_out to the core reset while rstn_in stays
 * a power-on reset so that the cause flags survive.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Expiry without valid clear resets device
// - Clear in closed window resets too
// - Mode 11: always active, even asleep
// - Mode 10: active awake, off in sleep
// - Mode 01: software bit switches it on
// - Clock source from config or run-time select
// - Period from prescale field when config 11111
// - Code 0 divides 32, doubling, big codes minimum
// - Prescale resets to 01011, two seconds
// - Span from run-time field when config 111
// - Window from five top count bits
// - Violation clears flag; power-on or software sets
// - Count clears on listed events and writes
// - Windowed clear needs prior arming read
// - Sleep entry and exit clear count
// - Expiry in sleep wakes, updates status
// - Dog reset recorded in cause flag
// - Idle expiry wakes instead of resetting
// - Start-up holds clear; oscillator fail clears
// - Software enable ignored in modes 1x
module wwd_top
    import wwd_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    // Register port.
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Configuration levels.
    input  wire logic [1:0] operating_mode_config_in,
    input  wire logic [2:0] config_clock_select_in,
    input  wire logic [4:0] config_period_select_in,
    input  wire logic [2:0] config_span_select_in,
    // Core and power state.
    input  wire logic       watchdog_clear_instr_in,
    input  wire logic       sleep_in,
    input  wire logic       idle_in,
    input  wire logic       sleep_entry_in,
    input  wire logic       sleep_exit_in,
    input  wire logic       osc_startup_timer_in,
    input  wire logic       osc_fail_in,
    // External oscillator ticks.
    input  wire logic       sosc_tick_in,
    input  wire logic       ext_tick_in,
    // Results.
    output logic            sys_reset_out,
    output logic            wake_out,
    output logic            running_out
);

    typedef struct packed {
        logic       swen;
        logic [4:0] presc;
        logic [2:0] clks;
        logic [2:0] span;
        logic       armed;
        logic       vio_n;
        logic       dog_n;
        logic       tmo_n;
        logic       slp_n;
        logic       run;
        logic       rst_p;
        logic       wake_p;
        logic [7:0] rdata;
    } wwd_state_t;

    wwd_state_t        st_q;
    wwd_state_t        st_d;
    logic              lf_tick;
    logic              mf_tick;
    logic              tick;
    logic              en;
    logic              cnt_clr;
    logic              expire;
    logic [CNT_W-1:0]  count;
    logic [SPAN_W-1:0] span_val;
    logic [4:0]        presc_raw;
    logic [4:0]        presc_eff;
    logic [2:0]        clks_eff;
    logic [2:0]        span_eff;
    logic              windowed;
    logic              open_win;
    logic              viol;
    logic              clr_ok;
    logic              dog_evt;
    logic              hold;
    logic              wr_a;
    logic              wr_b;
    logic              wr_p;
    logic              rd_a;

    ////////////////////////////////////////////////////////////////////////
    // Internal oscillator time bases.
    wwd_div #(.DIV(LF_DIV)) u_lf (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .tick_out (lf_tick)
    );

    wwd_div #(.DIV(MF_DIV)) u_mf (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .tick_out (mf_tick)
    );

    // Period counter.
    wwd_count u_cnt (
        .clock_in   (clock_in),
        .rstn_in    (rstn_in),
        .tick_in    (tick),
        .clear_in   (cnt_clr),
        .presc_in   (presc_eff),
        .count_out  (count),
        .span_out   (span_val),
        .expire_out (expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register strobes.
    assign wr_a = wr_in && (addr_in == ADDR_CTRL_A);
    assign wr_b = wr_in && (addr_in == ADDR_CTRL_B);
    assign wr_p = wr_in && (addr_in == ADDR_PWRCTL);
    assign rd_a = rd_in && (addr_in == ADDR_CTRL_A);

    // Selections between configuration and run-time fields.
    always_comb begin
        presc_raw = (config_period_select_in == PRESC_CFG_SW) ?
                    st_q.presc : config_period_select_in;
        presc_eff = (presc_raw > PRESC_MAX) ? PRESC_MIN : presc_raw;
        clks_eff = (config_clock_select_in == CLKS_CFG_SW) ?
                   st_q.clks : config_clock_select_in;
        span_eff = (config_span_select_in == SPAN_CFG_SW) ?
                   st_q.span : config_span_select_in;
        windowed = (span_eff != SPAN_FULL);
        open_win = (span_val >= {~span_eff, 2'b00});
    end

    // Operating mode decides whether the watchdog runs at all.
    always_comb begin
        unique case (operating_mode_config_in)
            MODE_ON:    en = 1'b1;
            MODE_AWAKE: en = !sleep_in;
            MODE_SW:    en = st_q.swen;
            MODE_OFF:   en = 1'b0;
        endcase
    end

    // Clock source; reserved codes leave the counter stopped.
    always_comb begin
        case (clks_eff)
            CLKS_LF:   tick = lf_tick;
            CLKS_MF:   tick = mf_tick;
            CLKS_SOSC: tick = sosc_tick_in;
            CLKS_EXT:  tick = ext_tick_in;
            default:   tick = 1'b0;
        endcase
    end

    // Clear instruction check and the watchdog events.
    always_comb begin
        viol = watchdog_clear_instr_in && en && windowed &&
               !(st_q.armed && open_win);
        clr_ok = watchdog_clear_instr_in && en && !viol;
        dog_evt = expire || viol;
        hold = sleep_in || idle_in;
    end

    // Every condition that zeroes the count.
    always_comb begin
        // Expiry is left out on purpose: the counter restarts by itself, and feeding it back would form a loop.
        cnt_clr = !en || clr_ok || wr_a || wr_b || st_q.rst_p || viol;
        cnt_clr = cnt_clr || sleep_entry_in || sleep_exit_in;
        cnt_clr = cnt_clr || osc_startup_timer_in || osc_fail_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: registers, flags, events and read data.
    always_comb begin
        st_d = st_q;
        st_d.rdata = 8'h00;
        st_d.rst_p = dog_evt && !hold;
        st_d.wake_p = dog_evt && hold;
        st_d.run = en;
        // Register writes; read-only fields ignore them.
        if (wr_a) begin
            st_d.swen = wdata_in[SWEN_BIT];
            if (config_period_select_in == PRESC_CFG_SW) begin
                st_d.presc = wdata_in[PRESC_LSB +: 5];
            end
        end
        if (wr_b && config_clock_select_in == CLKS_CFG_SW) begin
            st_d.clks = wdata_in[CLKS_LSB +: 3];
        end
        if (wr_b && config_span_select_in == SPAN_CFG_SW) begin
            st_d.span = wdata_in[SPAN_LSB +: 3];
        end
        // Arming: a read of control A arms, a clear or reset disarms.
        if (rd_a) begin
            st_d.armed = 1'b1;
        end else if (watchdog_clear_instr_in || st_d.rst_p) begin
            st_d.armed = 1'b0;
        end
        // Software may write the cause and status flags.
        if (wr_p) begin
            st_d.vio_n = wdata_in[VIO_BIT];
            st_d.dog_n = wdata_in[DOG_BIT];
            st_d.tmo_n = wdata_in[TMO_BIT];
            st_d.slp_n = wdata_in[SLP_BIT];
        end
        // Hardware events win over a software write in the same cycle.
        if (sleep_entry_in) begin
            st_d.tmo_n = 1'b1;
            st_d.slp_n = 1'b0;
        end
        if (expire && sleep_in) begin
            st_d.tmo_n = 1'b0;
        end
        if (viol && !hold) begin
            st_d.vio_n = 1'b0;
        end
        if (st_d.rst_p) begin
            st_d.dog_n = 1'b0;
        end
        // Read data, valid only in the cycle after the strobe.
        if (rd_in) begin
            unique case (addr_in)
                ADDR_CTRL_A: st_d.rdata = {2'h0, presc_raw, st_q.swen};
                ADDR_CTRL_B: st_d.rdata = {1'b0, clks_eff, 1'b0, span_eff};
                ADDR_CNT_LO: st_d.rdata = count[7:0];
                ADDR_CNT_HI: st_d.rdata = count[15:8];
                ADDR_COUNT:  st_d.rdata = {span_val, st_q.armed, count[17:16]};
                ADDR_PWRCTL: st_d.rdata = {4'h0, st_q.slp_n, st_q.tmo_n, st_q.dog_n, st_q.vio_n};
                default:     st_d.rdata = 8'h00;
            endcase
        end
        // Power-on reset; fields with a configured value take it.
        if (!rstn_in) begin
            st_d = '0;
            st_d.presc = (config_period_select_in == PRESC_CFG_SW) ?
                         PRESC_RESET : config_period_select_in;
            st_d.clks = (config_clock_select_in == CLKS_CFG_SW) ?
                        CLKS_RESET : config_clock_select_in;
            st_d.span = config_span_select_in;
            st_d.vio_n = 1'b1;
            st_d.dog_n = 1'b1;
            st_d.tmo_n = 1'b1;
            st_d.slp_n = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock_in) begin
        st_q <= st_d;
    end

    // Outputs straight from flip-flops.
    assign rdata_out = st_q.rdata;
    assign sys_reset_out = st_q.rst_p;
    assign wake_out = st_q.wake_p;
    assign running_out = st_q.run;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    expiry_reset_a : assert property (expire && !hold |=> sys_reset_out)
        else $error("expiry awake gave no reset");
    closed_clear_a : assert property (watchdog_clear_instr_in && en && windowed
        && !open_win && !hold |=> sys_reset_out && !wake_out)
        else $error("closed window clear gave no reset");
    always_on_a : assert property (operating_mode_config_in == MODE_ON
        |=> running_out)
        else $error("mode on but not running");
    awake_only_a : assert property (operating_mode_config_in == MODE_AWAKE
        && sleep_in |=> !running_out)
        else $error("running in sleep in awake mode");
    soft_enable_a : assert property (operating_mode_config_in == MODE_SW
        |=> running_out == $past(st_q.swen))
        else $error("software mode ignores enable bit");
    presc_reset_a : assert property (@(posedge clock_in) disable iff (1'b0) !rstn_in &&
        config_period_select_in == PRESC_CFG_SW |=> st_q.presc == PRESC_RESET)
        else $error("prescale reset value wrong");
    write_clear_a : assert property (wr_a || wr_b |=> count == '0)
        else $error("control write did not clear count");
    unarmed_clear_a : assert property (watchdog_clear_instr_in && en && windowed
        && !st_q.armed && !hold |=> sys_reset_out ##1 !sys_reset_out)
        else $error("unarmed clear was accepted");
    viol_flag_a : assert property (viol && !hold && !wr_p
        |=> !st_q.vio_n && !st_q.dog_n)
        else $error("violation flags not cleared");
    idle_wake_a : assert property (expire && idle_in
        |=> wake_out && !sys_reset_out)
        else $error("idle expiry did not wake");
    mode_off_a : assert property (operating_mode_config_in == MODE_OFF
        |=> !running_out [*2])
        else $error("running while mode off");

    // Clear sources, sleep status and the cause flag.
    held_clear_a : assert property (osc_startup_timer_in |=> count == '0)
        else $error("count ran during start-up timing");
    sleep_entry_a : assert property (sleep_entry_in |=> count == '0 && !st_q.slp_n)
        else $error("sleep entry did not clear count");
    dog_cause_a : assert property (sys_reset_out |-> !st_q.dog_n)
        else $error("watchdog reset not recorded");
    disabled_clear_a : assert property (!en |=> count == '0)
        else $error("count moved while disabled");
    valid_clear_a : assert property (clr_ok |=> count == '0 && !sys_reset_out)
        else $error("valid clear did not restart count");
    arm_read_a : assert property (rd_a |=> st_q.armed)
        else $error("control read did not arm");
    sleep_expiry_a : assert property (expire && sleep_in
        |=> wake_out && !sys_reset_out && !st_q.tmo_n)
        else $error("sleep expiry did not wake");

    reset_seen_c : cover property (expire ##1 sys_reset_out);
    sleep_wake_c : cover property (expire && sleep_in ##1 wake_out);
    armed_clear_c : cover property (rd_a ##[1:50] clr_ok && windowed);
    idle_wake_c : cover property (expire && idle_in ##1 wake_out);
    window_reset_c : cover property (viol && !hold ##1 sys_reset_out);

endmodule // wwd_top

`default_nettype wire

// ==== wwd_pkg.sv ====
/*
 * Package for the windowed watchdog: register offsets, field positions,
 * reset values, mode codes and clock-rate constants.
 * Assumes a single 50 MHz system clock and a byte-wide register port.
 */
package wwd_pkg;

    // System clock and the internal watchdog oscillator rates, in Hz.
    localparam int CLK_HZ = 50_000_000;
    localparam int LF_HZ  = 31_000;
    localparam int MF_HZ  = 31_250;
    localparam int LF_DIV = CLK_HZ / LF_HZ;
    localparam int MF_DIV = CLK_HZ / MF_HZ;

    // Register offsets on the byte port.
    localparam logic [11:0] ADDR_CTRL_A = 12'h18c;
    localparam logic [11:0] ADDR_CTRL_B = 12'h18d;
    localparam logic [11:0] ADDR_CNT_LO = 12'h18e;
    localparam logic [11:0] ADDR_CNT_HI = 12'h18f;
    localparam logic [11:0] ADDR_COUNT  = 12'h190;
    localparam logic [11:0] ADDR_PWRCTL = 12'h191;

    // Field positions.
    localparam int SWEN_BIT  = 0;
    localparam int PRESC_LSB = 1;
    localparam int CLKS_LSB  = 4;
    localparam int SPAN_LSB  = 0;
    localparam int VIO_BIT   = 0;
    localparam int DOG_BIT   = 1;
    localparam int TMO_BIT   = 2;
    localparam int SLP_BIT   = 3;

    // Operating mode configuration codes.
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_SW    = 2'h1;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_ON    = 2'h3;

    // Prescale select codes and reset value.
    localparam logic [4:0] PRESC_CFG_SW = 5'h1f;
    localparam logic [4:0] PRESC_RESET  = 5'h0b;
    localparam logic [4:0] PRESC_MAX    = 5'h12;
    localparam logic [4:0] PRESC_MIN    = 5'h00;

    // Clock and span select codes.
    localparam logic [2:0] CLKS_CFG_SW = 3'h7;
    localparam logic [2:0] CLKS_RESET  = 3'h0;
    localparam logic [2:0] CLKS_LF     = 3'h0;
    localparam logic [2:0] CLKS_MF     = 3'h1;
    localparam logic [2:0] CLKS_SOSC   = 3'h2;
    localparam logic [2:0] CLKS_EXT    = 3'h3;
    localparam logic [2:0] SPAN_CFG_SW = 3'h7;
    localparam logic [2:0] SPAN_FULL   = 3'h7;

    // Counter geometry: a 1:32 base divide and 23 bits at the longest.
    localparam int PRE_BITS = 5;
    localparam int CNT_W    = 23;
    localparam int SPAN_W   = 5;

endpackage

// ==== wwd_div.sv ====
/*
 * Divider that turns the system clock into a one-cycle enable pulse at the
 * rate of one watchdog oscillator.
 * Assumes clock_in at the system rate and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module wwd_div
    import wwd_pkg::*;
#(
    parameter int DIV = LF_DIV
) (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic rstn_in,
    // Enable pulse out.
    output logic      tick_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } wwd_div_t;

    wwd_div_t st_q;
    wwd_div_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Count to the divide value and pulse once at the wrap.
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!rstn_in) begin
            st_d = '0;
        end else if (st_q.cnt == 16'(DIV - 1)) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    // State register.
    always_ff @(posedge clock_in) begin
        st_q <= st_d;
    end

    assign tick_out = st_q.tick;

endmodule // wwd_div

`default_nettype wire

// ==== wwd_count.sv ====
/*
 * Watchdog counter: a prescaler and 5-bit span value in one 23-bit count,
 * with a selectable period of 2^(presc+5) ticks.
 * Assumes presc_in already limited to 0..18 and tick_in one cycle long.
 */
`timescale 1ns/1ps
`default_nettype none

module wwd_count
    import wwd_pkg::*;
(
    // Clock and reset.
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    // Control.
    input  wire logic              tick_in,
    input  wire logic              clear_in,
    input  wire logic [4:0]        presc_in,
    // Status.
    output logic [CNT_W-1:0]       count_out,
    output logic [SPAN_W-1:0]      span_out,
    output logic                   expire_out
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } wwd_cnt_t;

    wwd_cnt_t         st_q;
    wwd_cnt_t         st_d;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] shifted;

    ////////////////////////////////////////////////////////////////////////
    // Terminal count and the five top bits of the selected period.
    always_comb begin
        limit = ~({CNT_W{1'b1}} << (presc_in + PRE_BITS));
        shifted = st_q.cnt >> presc_in;
        span_out = shifted[SPAN_W-1:0];
        expire_out = tick_in && !clear_in && (st_q.cnt == limit);
        count_out = st_q.cnt;
    end

    // Clear wins; a terminal tick restarts from zero.
    always_comb begin
        st_d = st_q;
        if (!rstn_in || clear_in) begin
            st_d.cnt = '0;
        end else if (tick_in) begin
            st_d.cnt = expire_out ? '0 : st_q.cnt + 23'h000001;
        end
    end

    // State register.
    always_ff @(posedge clock_in) begin
        st_q <= st_d;
    end

    // Shortest period expires after exactly 32 ticks.
    min_period_a : assert property (@(posedge clock_in) disable iff (!rstn_in)
        (tick_in && !clear_in && presc_in == PRESC_MIN && st_q.cnt == 23'h00001f)
        |-> expire_out) else $error("shortest period did not expire");

endmodule // wwd_count

`default_nettype wire

// ==== wwd_tb_top.sv ====
/*
 * Self-checking bench for the windowed watchdog core: register port, modes,
 * period and window selection, clear sources, sleep and idle wakes.
 * Assumes the package wwd_pkg; the bench makes the secondary and external ticks, the core divides its internal ones.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import wwd_pkg::*;
;
    logic        clock_in, rstn_in, wr_in, rd_in, rst_o, wake_o, run_o;
    logic [11:0] addr_in;
    logic [7:0]  wdata_in, rdata_out;
    logic [1:0]  mode;
    logic [2:0]  ccs, cws;
    logic [4:0]  cps, p;
    logic        clr_in, slp, idl, s_ent, s_ext, osc_startup_timer, ofail, sosc, ext, e;
    int          n_mismatch, compares, cyc, n_rst, n_wake, seed, k, m;

    wwd_top dut_u (
        .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .operating_mode_config_in(mode), .config_clock_select_in(ccs),
        .config_period_select_in(cps), .config_span_select_in(cws),
        .watchdog_clear_instr_in(clr_in), .sleep_in(slp), .idle_in(idl),
        .sleep_entry_in(s_ent), .sleep_exit_in(s_ext), .osc_startup_timer_in(osc_startup_timer),
        .osc_fail_in(ofail), .sosc_tick_in(sosc), .ext_tick_in(ext),
        .sys_reset_out(rst_o), .wake_out(wake_o), .running_out(run_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, pulse counting away from the sampling edge, and the hang limit.
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    always @(negedge clock_in) begin
        n_rst  = n_rst + int'(rst_o === 1'b1);
        n_wake = n_wake + int'(wake_o === 1'b1);
    end
    always @(posedge clock_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Model of the period in ticks: codes above 18 fall back to the minimum.
    function automatic int period(input logic [4:0] c);
        return (c > 5'd18) ? 32 : (32 << c);
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register writes and reads, each followed by one idle cycle.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        chk(rdata_out, x);
        @(posedge clock_in);
    endtask

    // Sends n ticks on one source: 0 external, 1 secondary.
    task automatic tick(input int n, input bit src);
        repeat (n) begin
            if (src) sosc <= 1'b1;
            else ext <= 1'b1;
            @(posedge clock_in);
            sosc <= 1'b0;
            ext  <= 1'b0;
            @(posedge clock_in);
        end
    endtask

    // Quiet for n-1 ticks, then the last tick must give the stated pulses.
    task automatic expire(input int n, input bit src, input int er, input int ew);
        int r0, w0;
        r0 = n_rst;
        w0 = n_wake;
        tick(n - 1, src);
        chk(8'(n_rst - r0), 8'h00);
        chk(8'(n_wake - w0), 8'h00);
        tick(1, src);
        chk(8'(n_rst - r0), 8'(er));
        chk(8'(n_wake - w0), 8'(ew));
    endtask

    // One clear instruction, then the pulses it must cause.
    task automatic clr(input int er, input int ew);
        int r0, w0;
        r0 = n_rst;
        w0 = n_wake;
        clr_in <= 1'b1;
        @(posedge clock_in);
        clr_in <= 1'b0;
        @(posedge clock_in);
        chk(8'(n_rst - r0), 8'(er));
        chk(8'(n_wake - w0), 8'(ew));
    endtask

    // Power-on reset with a new set of configuration levels.
    task automatic boot(input logic [1:0] md, input logic [2:0] cc, input logic [4:0] cp, input logic [2:0] cw);
        rstn_in <= 1'b0;
        mode    <= md;
        ccs     <= cc;
        cps     <= cp;
        cws     <= cw;
        slp     <= 1'b0;
        idl     <= 1'b0;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {rstn_in, wr_in, rd_in, addr_in, wdata_in, mode, ccs, cps, cws} = '0;
        {clr_in, slp, idl, s_ent, s_ext, osc_startup_timer, ofail, sosc, ext} = '0;
        {n_mismatch, compares, cyc, n_rst, n_wake} = '0;
        seed = 67;
        @(posedge clock_in);
        // Reset values and an unmapped address.
        boot(2'h3, 3'h7, 5'h1f, 3'h7);
        rdchk(ADDR_CTRL_A, 8'h16);
        rdchk(ADDR_CTRL_B, 8'h07);
        rdchk(ADDR_PWRCTL, 8'h0f);
        wr(12'h1ff, 8'hff);
        rdchk(12'h1ff, 8'h00);
        // Every mode against sleep level and software enable.
        for (m = 0; m < 4; m++) begin
            boot(m[1:0], 3'h7, 5'h1f, 3'h7);
            for (k = 0; k < 4; k++) begin
                slp <= k[1];
                wr(ADDR_CTRL_A, {7'h0b, k[0]});
                @(negedge clock_in);
                e = (m == 3) || (m == 2 && !k[1]) || (m == 1 && k[0]);
                chk({7'h0, run_o}, {7'h0, e});
                @(posedge clock_in);
            end
        end
        // Fixed period from configuration; writes to the field are ignored.
        boot(2'h3, 3'h3, 5'h01, 3'h7);
        rdchk(ADDR_CTRL_A, 8'h02);
        wr(ADDR_CTRL_A, 8'h00);
        rdchk(ADDR_CTRL_A, 8'h02);
        expire(64, 1'b0, 1, 0);
        rdchk(ADDR_PWRCTL, 8'h0d);
        // Run-time periods: minimum, reserved code, then random codes.
        boot(2'h3, 3'h3, 5'h1f, 3'h7);
        for (k = 0; k < 6; k++) begin
            p = 5'($random(seed));
            if (p > 5'd2 && p < 5'd19) p = 5'(p % 3);
            if (k < 2) p = k[0] ? 5'h1f : 5'h00;
            wr(ADDR_CTRL_A, {2'b00, p, 1'b1});
            if (p < 5'd19) rdchk(ADDR_CTRL_A, {2'b00, p, 1'b1});
            expire(period(p), 1'b0, 1, 0);
        end
        // Run-time clock source: secondary ticks count, external ones do not.
        boot(2'h3, 3'h7, 5'h1f, 3'h7);
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_CTRL_B, 8'h27);
        tick(40, 1'b0);
        expire(32, 1'b1, 1, 0);
        // Internal time bases: two and a half divider periods give two ticks.
        for (k = 0; k < 2; k++) begin
            boot(2'h3, k[2:0], 5'h00, 3'h7);
            repeat (k ? (5 * MF_DIV / 2) : (5 * LF_DIV / 2)) @(posedge clock_in);
            rdchk(ADDR_CNT_LO, 8'h02);
        end
        // Window with fixed span 011: open from span value 16 on.
        boot(2'h3, 3'h3, 5'h00, 3'h3);
        rdchk(ADDR_CTRL_B, 8'h33);
        clr(1, 0);
        rdchk(ADDR_PWRCTL, 8'h0c);
        wr(ADDR_PWRCTL, 8'h0f);
        rdchk(ADDR_PWRCTL, 8'h0f);
        rdchk(ADDR_CTRL_A, 8'h00);
        tick(15, 1'b0);
        clr(1, 0);
        tick(16, 1'b0);
        rdchk(ADDR_CTRL_A, 8'h00);
        clr(0, 0);
        rdchk(ADDR_COUNT, 8'h00);
        tick(3, 1'b0);
        rdchk(ADDR_COUNT, 8'h18);
        expire(29, 1'b0, 1, 0);
        idl <= 1'b1;
        clr(0, 1);
        idl <= 1'b0;
        // Clear sources mid-period: start-up timer, failure, wake, write.
        boot(2'h3, 3'h3, 5'h00, 3'h7);
        for (k = 0; k < 4; k++) begin
            tick(20, 1'b0);
            case (k)
                0: begin
                    osc_startup_timer <= 1'b1;
                    tick(5, 1'b0);
                    osc_startup_timer <= 1'b0;
                end
                1: ofail <= 1'b1;
                2: s_ext <= 1'b1;
                default: wr(ADDR_CTRL_B, 8'h00);
            endcase
            @(posedge clock_in);
            ofail <= 1'b0;
            s_ext <= 1'b0;
            @(posedge clock_in);
            expire(32, 1'b0, 1, 0);
        end
        // Expiry asleep and idle wakes instead of resetting.
        s_ent <= 1'b1;
        slp   <= 1'b1;
        @(posedge clock_in);
        s_ent <= 1'b0;
        @(posedge clock_in);
        expire(32, 1'b0, 0, 1);
        rdchk(ADDR_PWRCTL, 8'h01);
        slp <= 1'b0;
        idl <= 1'b1;
        expire(32, 1'b0, 0, 1);
        rdchk(ADDR_PWRCTL, 8'h01);
        // Mode 10 stays quiet through sleep.
        boot(2'h2, 3'h3, 5'h00, 3'h7);
        slp <= 1'b1;
        expire(40, 1'b0, 0, 0);
        close_out();
    end

endmodule // tb_top

`default_nettype wire
